// >>> mcpin_pkg.sv
// Package with constants and types for the memory controller pin interface
package mcpin_pkg;
  // Machine selection codes
  localparam logic [1:0] MACH_CHIPSEL = 2'h0;
  localparam logic [1:0] MACH_SDRAM = 2'h1;
  localparam logic [1:0] MACH_PATTERN = 2'h2;
  // Port size codes
  localparam logic [1:0] PORT_8 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;
  localparam logic [1:0] PORT_64 = 2'h3;
  // Buffer control function field codes
  localparam logic [1:0] BCTL_RW_OE = 2'h0;
  localparam logic [1:0] BCTL_OE_ONLY = 2'h1;
  localparam logic [1:0] BCTL_DELAYED = 2'h2;
  // Pattern word layout
  localparam int PAT_GPL_LSB = 0;
  localparam int PAT_BS_BIT = 6;
  localparam int PAT_LAST_BIT = 7;
  localparam int PAT_WAIT_BIT = 8;
  localparam int PAT_WIDTH = 9;
  localparam int PAT_DEPTH = 16;
  localparam int PAT_AW = 4;
  // Counts of cycles
  localparam logic [3:0] SDRAM_RCD_CYC = 4'h2;
  localparam logic [3:0] SDRAM_CAS_CYC = 4'h2;
  // Values after reset
  localparam logic [7:0] LANES_IDLE = 8'hff;
  localparam logic [5:0] GPL_IDLE = 6'h3f;
  typedef enum logic [4:0] {
    MCPIN_IDLE = 5'h01,
    MCPIN_CS = 5'h02,
    MCPIN_ROW = 5'h04,
    MCPIN_COL = 5'h08,
    MCPIN_PAT = 5'h10
  } mcpin_state_t;
endpackage : mcpin_pkg

// >>> mcpin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
module mcpin_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_ff, s2_ff, s3_ff, lvl_ff;
  logic nxt_lvl;

  always_comb
  begin
    nxt_lvl = lvl_ff;
    if (s2_ff == s3_ff)
    begin
      nxt_lvl = s3_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;
endmodule : mcpin_sync

// >>> mcpin_ctrl.sv
// Memory controller pin engine: chip-select, SDRAM and pattern machines
// How it works
// - Eight active-low chip selects, one per attached device, follow the access bank.
// - The chip-select machine drives eight active-low byte write enables on writes.
// - The chip-select machine drives an active-low output enable during reads.
// - A chip-select access ends when the transfer-acknowledge input is seen low.
// - The pattern machine holds its step while the wait input is high and the current word has its wait bit set.
// - Pattern byte selects come from address, size and port width, timed by the pattern.
// - Six general-purpose lines take their levels from the pattern word.
// - A10 carries the address bit during the row phase and the command bit in the column phase.
// - Row strobe, column strobe and write command lines are driven for SDRAM.
// - Eight SDRAM data masks select byte lanes.
// - In external master mode the SDRAM address multiplexer control is driven.
// - In external master mode the address latch enable pulses at access start.
// - Two buffer controls behave as the buffer-control function field selects.
// - The parity byte select is asserted during accesses to the parity chip.
// - Burst address bits 27 and 28 are driven from the access address.
module mcpin_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Access request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_machine,
  input wire logic [2:0] req_bank,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_size,
  input wire logic [1:0] req_port,
  input wire logic req_parity,
  output logic done_pulse,
  // Configuration
  input wire logic ext_master_mode,
  input wire logic [1:0] buffer_ctrl_function_field,
  input wire logic sdram_a10_cmd,
  // Pattern memory load
  input wire logic pat_we,
  input wire logic [3:0] pat_waddr,
  input wire logic [8:0] pat_wdata,
  input wire logic [3:0] pat_start,
  // Pins in
  input wire logic chipsel_transfer_ack,
  input wire logic pattern_wait_in,
  // Pins out
  output logic [7:0] chip_selects_n,
  output logic [7:0] byte_write_enables,
  output logic read_output_enable,
  output logic [7:0] pattern_byte_selects,
  output logic pattern_line_zero,
  output logic pattern_line_one,
  output logic pattern_line_two,
  output logic pattern_line_three,
  output logic pattern_line_four,
  output logic pattern_line_five,
  output logic sdram_addr_ten,
  output logic sdram_row_strobe,
  output logic sdram_col_strobe,
  output logic sdram_write_cmd,
  output logic [7:0] sdram_data_masks,
  output logic sdram_addr_mux_ctrl,
  output logic addr_latch_enable,
  output logic buffer_ctrl_zero,
  output logic buffer_ctrl_one,
  output logic parity_byte_select,
  output logic [1:0] burst_addr_bits
);
  logic ta_lvl, wait_lvl;
  // Ack inverted so the synchroniser's reset level matches the pulled-up idle pin
  mcpin_sync u_ta (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_in(~chipsel_transfer_ack),
    .level_out(ta_lvl)
  );
  mcpin_sync u_wait (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_in(pattern_wait_in),
    .level_out(wait_lvl)
  );

  // Active lane mask (high = lane used) from address, size and port
  function automatic logic [7:0] lane_mask(input logic [2:0] a, input logic [3:0] sz, input logic [1:0] port);
    logic [15:0] m;
    logic [2:0] off;
    m = 16'h0000;
    off = 3'h0;
    case (port)
      mcpin_pkg::PORT_8: off = 3'h0;
      mcpin_pkg::PORT_16: off = {2'h0, a[0]};
      mcpin_pkg::PORT_32: off = {1'b0, a[1:0]};
      default: off = a;
    endcase
    case (sz)
      4'h1: m = 16'h0001;
      4'h2: m = 16'h0003;
      4'h4: m = 16'h000f;
      default: m = 16'h00ff;
    endcase
    m = m << off;
    case (port)
      mcpin_pkg::PORT_8: lane_mask = 8'h01;
      mcpin_pkg::PORT_16: lane_mask = m[7:0] & 8'h03;
      mcpin_pkg::PORT_32: lane_mask = m[7:0] & 8'h0f;
      default: lane_mask = m[7:0];
    endcase
  endfunction : lane_mask

  logic [8:0] pat_mem [0:15];
  mcpin_pkg::mcpin_state_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] pc_ff, nxt_pc;
  logic [2:0] bank_ff, nxt_bank;
  logic wr_ff, nxt_wr;
  logic par_ff, nxt_par;
  logic [7:0] lanes_ff, nxt_lanes;
  logic [1:0] baddr_ff, nxt_baddr;
  logic a10_ff, nxt_a10;
  logic a10_cmd_ff, nxt_a10_cmd;
  logic ale_ff, nxt_ale;
  logic done_ff, nxt_done;
  logic [7:0] cs_ff, nxt_cs, we_ff, nxt_we, bs_ff, nxt_bs, dqm_ff, nxt_dqm;
  logic oe_ff, nxt_oe, ras_ff, nxt_ras, cas_ff, nxt_cas, swe_ff, nxt_swe;
  logic amux_ff, nxt_amux, b0_ff, nxt_b0, b1_ff, nxt_b1, pbs_ff, nxt_pbs;
  logic [5:0] gpl_ff, nxt_gpl;
  logic [8:0] pword;
  logic busy_nxt;

  always_ff @(posedge sys_clk)
  begin
    if (pat_we)
    begin
      pat_mem[pat_waddr] <= pat_wdata;
    end
  end

  assign pword = pat_mem[pc_ff];
  assign req_ready = (st_ff == mcpin_pkg::MCPIN_IDLE);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_pc = pc_ff;
    nxt_bank = bank_ff;
    nxt_wr = wr_ff;
    nxt_par = par_ff;
    nxt_lanes = lanes_ff;
    nxt_baddr = baddr_ff;
    nxt_a10 = a10_ff;
    nxt_a10_cmd = a10_cmd_ff;
    nxt_ale = 1'b0;
    nxt_done = 1'b0;
    case (st_ff)
      mcpin_pkg::MCPIN_IDLE:
      begin
        if (req_valid)
        begin
          nxt_bank = req_bank;
          nxt_wr = req_write;
          nxt_par = req_parity;
          nxt_lanes = lane_mask(req_addr[2:0], req_size, req_port);
          nxt_baddr = req_addr[4:3];
          nxt_a10 = req_addr[10];
          nxt_a10_cmd = sdram_a10_cmd;
          nxt_ale = ext_master_mode;
          nxt_cnt = 4'h0;
          nxt_pc = pat_start;
          case (req_machine)
            mcpin_pkg::MACH_SDRAM: nxt_st = mcpin_pkg::MCPIN_ROW;
            mcpin_pkg::MACH_PATTERN: nxt_st = mcpin_pkg::MCPIN_PAT;
            default: nxt_st = mcpin_pkg::MCPIN_CS;
          endcase
        end
      end
      mcpin_pkg::MCPIN_CS:
      begin
        if (ta_lvl)
        begin
          nxt_st = mcpin_pkg::MCPIN_IDLE;
          nxt_done = 1'b1;
        end
      end
      mcpin_pkg::MCPIN_ROW:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == mcpin_pkg::SDRAM_RCD_CYC - 4'h1)
        begin
          nxt_st = mcpin_pkg::MCPIN_COL;
          nxt_cnt = 4'h0;
        end
      end
      mcpin_pkg::MCPIN_COL:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == mcpin_pkg::SDRAM_CAS_CYC - 4'h1)
        begin
          nxt_st = mcpin_pkg::MCPIN_IDLE;
          nxt_done = 1'b1;
        end
      end
      mcpin_pkg::MCPIN_PAT:
      begin
        if (!(pword[mcpin_pkg::PAT_WAIT_BIT] && wait_lvl))
        begin
          if (pword[mcpin_pkg::PAT_LAST_BIT])
          begin
            nxt_st = mcpin_pkg::MCPIN_IDLE;
            nxt_done = 1'b1;
          end
          else
          begin
            nxt_pc = pc_ff + 4'h1;
          end
        end
      end
      default: nxt_st = mcpin_pkg::MCPIN_IDLE;
    endcase
  end

  // Pin levels registered from the next state
  always_comb
  begin
    busy_nxt = (nxt_st != mcpin_pkg::MCPIN_IDLE);
    nxt_cs = mcpin_pkg::LANES_IDLE;
    nxt_we = mcpin_pkg::LANES_IDLE;
    nxt_oe = 1'b1;
    nxt_bs = mcpin_pkg::LANES_IDLE;
    nxt_gpl = mcpin_pkg::GPL_IDLE;
    nxt_ras = 1'b1;
    nxt_cas = 1'b1;
    nxt_swe = 1'b1;
    nxt_dqm = mcpin_pkg::LANES_IDLE;
    nxt_amux = 1'b0;
    nxt_pbs = 1'b1;
    nxt_b0 = 1'b0;
    nxt_b1 = 1'b0;
    if (busy_nxt)
    begin
      nxt_cs = ~(8'h01 << nxt_bank);
      nxt_pbs = ~nxt_par;
      case (buffer_ctrl_function_field)
        mcpin_pkg::BCTL_RW_OE:
        begin
          nxt_b0 = nxt_wr;
          nxt_b1 = ~nxt_wr;
        end
        mcpin_pkg::BCTL_OE_ONLY:
        begin
          nxt_b0 = 1'b1;
          nxt_b1 = 1'b0;
        end
        default:
        begin
          nxt_b0 = nxt_wr;
          nxt_b1 = b0_ff;
        end
      endcase
    end
    case (nxt_st)
      mcpin_pkg::MCPIN_CS:
      begin
        if (nxt_wr)
        begin
          nxt_we = ~nxt_lanes;
        end
        else
        begin
          nxt_oe = 1'b0;
        end
      end
      mcpin_pkg::MCPIN_ROW:
      begin
        nxt_amux = ext_master_mode;
        if (nxt_cnt == 4'h0)
        begin
          nxt_ras = 1'b0;
        end
      end
      mcpin_pkg::MCPIN_COL:
      begin
        nxt_dqm = ~nxt_lanes;
        if (nxt_cnt == 4'h0)
        begin
          nxt_cas = 1'b0;
          nxt_swe = ~nxt_wr;
        end
      end
      mcpin_pkg::MCPIN_PAT:
      begin
        nxt_gpl = pat_mem[nxt_pc][5:0];
        if (pat_mem[nxt_pc][mcpin_pkg::PAT_BS_BIT])
        begin
          nxt_bs = ~nxt_lanes;
        end
      end
      default: nxt_amux = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= mcpin_pkg::MCPIN_IDLE;
      cnt_ff <= 4'h0;
      pc_ff <= 4'h0;
      bank_ff <= 3'h0;
      wr_ff <= 1'b0;
      par_ff <= 1'b0;
      lanes_ff <= 8'h00;
      baddr_ff <= 2'h0;
      a10_ff <= 1'b0;
      a10_cmd_ff <= 1'b0;
      ale_ff <= 1'b0;
      done_ff <= 1'b0;
      cs_ff <= mcpin_pkg::LANES_IDLE;
      we_ff <= mcpin_pkg::LANES_IDLE;
      oe_ff <= 1'b1;
      bs_ff <= mcpin_pkg::LANES_IDLE;
      gpl_ff <= mcpin_pkg::GPL_IDLE;
      ras_ff <= 1'b1;
      cas_ff <= 1'b1;
      swe_ff <= 1'b1;
      dqm_ff <= mcpin_pkg::LANES_IDLE;
      amux_ff <= 1'b0;
      pbs_ff <= 1'b1;
      b0_ff <= 1'b0;
      b1_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      pc_ff <= nxt_pc;
      bank_ff <= nxt_bank;
      wr_ff <= nxt_wr;
      par_ff <= nxt_par;
      lanes_ff <= nxt_lanes;
      baddr_ff <= nxt_baddr;
      a10_ff <= nxt_a10;
      a10_cmd_ff <= nxt_a10_cmd;
      ale_ff <= nxt_ale;
      done_ff <= nxt_done;
      cs_ff <= nxt_cs;
      we_ff <= nxt_we;
      oe_ff <= nxt_oe;
      bs_ff <= nxt_bs;
      gpl_ff <= nxt_gpl;
      ras_ff <= nxt_ras;
      cas_ff <= nxt_cas;
      swe_ff <= nxt_swe;
      dqm_ff <= nxt_dqm;
      amux_ff <= nxt_amux;
      pbs_ff <= nxt_pbs;
      b0_ff <= nxt_b0;
      b1_ff <= nxt_b1;
    end
  end

  // A10 muxed: row address bit, then command bit
  always_comb
  begin
    sdram_addr_ten = 1'b0;
    if (st_ff == mcpin_pkg::MCPIN_ROW)
    begin
      sdram_addr_ten = a10_ff;
    end
    else if (st_ff == mcpin_pkg::MCPIN_COL)
    begin
      sdram_addr_ten = a10_cmd_ff;
    end
  end

  assign done_pulse = done_ff;
  assign chip_selects_n = cs_ff;
  assign byte_write_enables = we_ff;
  assign read_output_enable = oe_ff;
  assign pattern_byte_selects = bs_ff;
  assign pattern_line_zero = gpl_ff[0];
  assign pattern_line_one = gpl_ff[1];
  assign pattern_line_two = gpl_ff[2];
  assign pattern_line_three = gpl_ff[3];
  assign pattern_line_four = gpl_ff[4];
  assign pattern_line_five = gpl_ff[5];
  assign sdram_row_strobe = ras_ff;
  assign sdram_col_strobe = cas_ff;
  assign sdram_write_cmd = swe_ff;
  assign sdram_data_masks = dqm_ff;
  assign sdram_addr_mux_ctrl = amux_ff;
  assign addr_latch_enable = ale_ff;
  assign buffer_ctrl_zero = b0_ff;
  assign buffer_ctrl_one = b1_ff;
  assign parity_byte_select = pbs_ff;
  assign burst_addr_bits = baddr_ff;
endmodule : mcpin_ctrl

// >>> mcpin_ctrl_props.sv
// Checker of pin timing for the memory controller pin engine
module mcpin_ctrl_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_machine,
  input wire logic [31:0] req_addr,
  input wire logic done_pulse,
  input wire logic ext_master_mode,
  input wire logic sdram_a10_cmd,
  // Pins
  input wire logic chipsel_transfer_ack,
  input wire logic [7:0] chip_selects_n,
  input wire logic read_output_enable,
  input wire logic sdram_addr_ten,
  input wire logic sdram_row_strobe,
  input wire logic sdram_col_strobe,
  input wire logic sdram_addr_mux_ctrl,
  input wire logic addr_latch_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic a10_ff;
  logic nxt_a10;
  logic take;
  assign take = req_valid && req_ready;
  always_comb nxt_a10 = take ? req_addr[10] : a10_ff;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      a10_ff <= 1'b0;
    else
      a10_ff <= nxt_a10;
  // Marks a chip-select machine access in flight
  logic cs_acc_ff;
  logic nxt_cs_acc;
  always_comb
  begin
    nxt_cs_acc = cs_acc_ff;
    if (take)
      nxt_cs_acc = (req_machine != mcpin_pkg::MACH_SDRAM) && (req_machine != mcpin_pkg::MACH_PATTERN);
    else if (done_pulse)
      nxt_cs_acc = 1'b0;
  end
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      cs_acc_ff <= 1'b0;
    else
      cs_acc_ff <= nxt_cs_acc;
  chk_idle_pins: assert property (req_ready |-> chip_selects_n == 8'hff && read_output_enable
    && sdram_row_strobe && sdram_col_strobe) else $error("pins active while idle");
  chk_single_cs: assert property ($countones(~chip_selects_n) <= 1) else $error("two chip selects");
  chk_sdram_walk: assert property (take && req_machine == mcpin_pkg::MACH_SDRAM |=> !sdram_row_strobe
    ##1 sdram_row_strobe ##1 !sdram_col_strobe ##1 sdram_col_strobe ##1 done_pulse) else $error("bad sdram walk");
  chk_a10_row: assert property (!sdram_row_strobe |-> sdram_addr_ten == a10_ff) else $error("a10 row");
  chk_a10_col: assert property (!sdram_col_strobe |-> sdram_addr_ten == sdram_a10_cmd) else $error("a10 col");
  chk_ack_ends: assert property (cs_acc_ff && $fell(chipsel_transfer_ack) |-> ##[3:8] done_pulse)
    else $error("ack did not end access");
  chk_ale_pulse: assert property (addr_latch_enable |-> ext_master_mode ##1 !addr_latch_enable)
    else $error("latch enable not a pulse");
  chk_amux_ext: assert property (sdram_addr_mux_ctrl |-> ext_master_mode) else $error("mux outside mode");
  chk_oe_read: assert property (!read_output_enable |-> chip_selects_n != 8'hff) else $error("oe no select");
  cov_sdram: cover property (take && req_machine == mcpin_pkg::MACH_SDRAM);
  cov_pattern: cover property (take && req_machine == mcpin_pkg::MACH_PATTERN);
  cov_ack: cover property ($fell(chipsel_transfer_ack));
endmodule : mcpin_ctrl_props

bind mcpin_ctrl mcpin_ctrl_props u_props (.sys_clk, .resetn, .req_valid, .req_ready, .req_machine, .req_addr,
  .done_pulse, .ext_master_mode, .sdram_a10_cmd, .chipsel_transfer_ack, .chip_selects_n, .read_output_enable,
  .sdram_addr_ten, .sdram_row_strobe, .sdram_col_strobe, .sdram_addr_mux_ctrl, .addr_latch_enable);

// >>> mcpin_far_model.sv
// Far-side model: acknowledging device and wait source
module mcpin_far_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Stall length set by the bench
  input wire logic [4:0] stall_len,
  // Pins from the controller
  input wire logic [7:0] chip_selects_n,
  input wire logic [7:0] pattern_byte_selects,
  // Pins to the controller
  output logic chipsel_transfer_ack,
  output logic pattern_wait_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cs_cnt;
  logic [4:0] run_cnt;
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_cnt <= 5'h00;
      run_cnt <= 5'h00;
    end
    else
    begin
      cs_cnt <= (chip_selects_n == 8'hff) ? 5'h00 : cs_cnt + (cs_cnt != 5'h1f);
      run_cnt <= ((chip_selects_n & pattern_byte_selects) == 8'hff) ? 5'h00 : run_cnt + (run_cnt != 5'h1f);
    end
  end
  // Ack low two cycles into a select, pulled up once released
  assign chipsel_transfer_ack = (cs_cnt < 5'h02);
  assign pattern_wait_in = (run_cnt < stall_len);
endmodule : mcpin_far_model

// >>> testbench.sv
// Self-checking bench for the memory controller pin engine
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_machine = 2'h0;
  logic [2:0] req_bank = 3'h0;
  logic req_write = 1'b0;
  logic [31:0] req_addr = 32'h00000418;
  logic [3:0] req_size = 4'h8;
  logic [1:0] req_port = mcpin_pkg::PORT_64;
  logic req_parity = 1'b0;
  logic ext_master_mode = 1'b0;
  logic [1:0] buffer_ctrl_function_field = 2'h0;
  logic sdram_a10_cmd = 1'b0;
  logic pat_we = 1'b0;
  logic [3:0] pat_waddr = 4'h0;
  logic [8:0] pat_wdata = 9'h000;
  logic [3:0] pat_start = 4'h3;
  logic [4:0] stall_len = 5'h00;
  logic req_ready, done_pulse, chipsel_transfer_ack, pattern_wait_in, read_output_enable;
  logic sdram_addr_ten, sdram_row_strobe, sdram_col_strobe, sdram_write_cmd, sdram_addr_mux_ctrl;
  logic addr_latch_enable, buffer_ctrl_zero, buffer_ctrl_one, parity_byte_select;
  logic [7:0] chip_selects_n, byte_write_enables, pattern_byte_selects, sdram_data_masks;
  logic [5:0] gpl;
  logic [1:0] burst_addr_bits;
  int errors = 0;
  int samples_checked = 0;
  int n0;
  int n1;
  always #2.5 sys_clk = ~sys_clk;
  mcpin_ctrl dut (.sys_clk, .resetn, .req_valid, .req_ready, .req_machine, .req_bank, .req_write, .req_addr,
    .req_size, .req_port, .req_parity, .done_pulse, .ext_master_mode, .buffer_ctrl_function_field,
    .sdram_a10_cmd, .pat_we, .pat_waddr, .pat_wdata, .pat_start, .chipsel_transfer_ack, .pattern_wait_in,
    .chip_selects_n, .byte_write_enables, .read_output_enable, .pattern_byte_selects,
    .pattern_line_zero(gpl[0]), .pattern_line_one(gpl[1]), .pattern_line_two(gpl[2]),
    .pattern_line_three(gpl[3]), .pattern_line_four(gpl[4]), .pattern_line_five(gpl[5]),
    .sdram_addr_ten, .sdram_row_strobe, .sdram_col_strobe, .sdram_write_cmd, .sdram_data_masks,
    .sdram_addr_mux_ctrl, .addr_latch_enable, .buffer_ctrl_zero, .buffer_ctrl_one, .parity_byte_select,
    .burst_addr_bits);
  mcpin_far_model far (.sys_clk, .resetn, .stall_len, .chip_selects_n, .pattern_byte_selects,
    .chipsel_transfer_ack, .pattern_wait_in);
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic start(input logic [1:0] mach, input logic [2:0] bank, input logic wr);
    req_machine = mach;
    req_bank = bank;
    req_write = wr;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    cmp8({7'h00, req_ready}, 8'h00, "taken");
  endtask : start
  task automatic wait_done(output int n);
    n = 0;
    while (done_pulse !== 1'b1)
    begin
      @(negedge sys_clk);
      n++;
      if (n > 60)
      begin
        errors++;
        $display("Error at %0t: no completion", $time);
        end_sim();
      end
    end
    @(negedge sys_clk);
  endtask : wait_done
  task automatic t_cs(input logic wr, input logic [2:0] bank, input logic [1:0] fld, input logic [1:0] bexp);
    int n;
    buffer_ctrl_function_field = fld;
    req_parity = 1'b1;
    start(mcpin_pkg::MACH_CHIPSEL, bank, wr);
    repeat (2) @(negedge sys_clk);
    cmp8(chip_selects_n, ~(8'h01 << bank), "select");
    cmp8(byte_write_enables, wr ? 8'h00 : 8'hff, "write lanes");
    cmp8({7'h00, read_output_enable}, {7'h00, wr}, "oe");
    cmp8({6'h00, burst_addr_bits}, 8'h03, "burst");
    cmp8({7'h00, parity_byte_select}, 8'h00, "parity");
    cmp8({6'h00, buffer_ctrl_zero, buffer_ctrl_one}, {6'h00, bexp}, "buffer ctrl");
    cmp8(pattern_byte_selects & sdram_data_masks, 8'hff, "others idle");
    wait_done(n);
    cmp8({7'h00, n >= 4}, 8'h01, "ack wait");
    // Released ack must drain through the synchroniser before the next access
    repeat (4) @(negedge sys_clk);
    $display("Test chip select bank %0d done", bank);
  endtask : t_cs
  task automatic t_sdram(input logic ext);
    int n;
    ext_master_mode = ext;
    sdram_a10_cmd = ext;
    start(mcpin_pkg::MACH_SDRAM, 3'h1, ext);
    cmp8({4'h0, sdram_addr_mux_ctrl, addr_latch_enable, sdram_addr_ten, sdram_row_strobe},
      {4'h0, ext, ext, 2'b10}, "row phase");
    repeat (2) @(negedge sys_clk);
    cmp8(sdram_data_masks, 8'h00, "masks");
    cmp8({5'h00, sdram_addr_ten, sdram_col_strobe, sdram_write_cmd},
      {5'h00, ext, 1'b0, ~ext}, "col phase");
    cmp8(byte_write_enables & pattern_byte_selects, 8'hff, "others idle");
    wait_done(n);
    $display("Test sdram mode %0d done", ext);
  endtask : t_sdram
  task automatic t_pat(input logic [4:0] stall, input logic [3:0] sz, input logic [1:0] port, input logic [7:0] bs_exp,
    output int n);
    int d;
    stall_len = stall;
    req_size = sz;
    req_port = port;
    // Wait level must pass the synchroniser before the first word
    repeat (4) @(negedge sys_clk);
    start(mcpin_pkg::MACH_PATTERN, 3'h3, 1'b0);
    cmp8({2'h0, gpl}, 8'h2a, "lines");
    cmp8(pattern_byte_selects, bs_exp, "byte sel");
    cmp8(byte_write_enables & sdram_data_masks, 8'hff, "others idle");
    n = 0;
    while (gpl !== 6'h15 && n < 60)
    begin
      @(negedge sys_clk);
      n++;
    end
    cmp8({2'h0, gpl, pattern_byte_selects[0]}, 8'h2b, "last word");
    wait_done(d);
    stall_len = 5'h00;
    $display("Test pattern stall %0d done", stall);
  endtask : t_pat
  initial
  begin
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    cmp8(chip_selects_n & byte_write_enables & sdram_data_masks & pattern_byte_selects, 8'hff, "reset");
    cmp8({1'b0, gpl, req_ready}, 8'h7f, "reset lines");
    pat_we = 1'b1;
    pat_waddr = 4'h3;
    pat_wdata = 9'h16a;
    @(negedge sys_clk);
    pat_waddr = 4'h4;
    pat_wdata = 9'h095;
    @(negedge sys_clk);
    pat_we = 1'b0;
    t_cs(1'b1, 3'h5, mcpin_pkg::BCTL_RW_OE, 2'h2);
    t_cs(1'b0, 3'h2, mcpin_pkg::BCTL_RW_OE, 2'h1);
    t_cs(1'b1, 3'h0, mcpin_pkg::BCTL_OE_ONLY, 2'h2);
    t_cs(1'b1, 3'h7, mcpin_pkg::BCTL_DELAYED, 2'h3);
    t_sdram(1'b0);
    t_sdram(1'b1);
    t_pat(5'h00, 4'h8, mcpin_pkg::PORT_64, 8'h00, n0);
    t_pat(5'h0c, 4'h2, mcpin_pkg::PORT_32, 8'hfc, n1);
    cmp8({7'h00, n1 >= n0 + 8}, 8'h01, "stall");
    end_sim();
  end
endmodule : testbench
